// [rs485_host_ctrl.sv]
// Purpose: local controller driving a polarity-correcting rs485 transceiver
// Assumes: transceiver pins wired directly; receive pin asynchronous
// Notes: polarity correction itself lives in the transceiver
//        drive requests win over standby requests while listening
//
// Functional notes
// [R01] standby only after enables disabled 300 ns
// [R02] brief disabled enables never cause standby
// [R03] re-enabling either side leaves standby
// [R04] detect only while listening, driver off, bus idle
// [R05] failsafe interval ends within 44 to 76 ms
// [R06] inversion applies to receive and transmit paths
// [R07] detected polarity stays latched afterwards
// [R08] power-up starts in normal, non-inverted polarity
// [R09] correcting mode after long valid-low idle input
// [R10] correcting state captured on receive enable rising; xcvr_model sets it when its idle count ends
// [R11] every power-up restarts detection, inversion cleared
// [R12] transmitter avoids runs beyond shortest failsafe interval
// [R13] master idles longer than longest interval first
// [R14] controller holds direction low after power-up
// [R15] normal mode drives data high as bus high
// [R16] correcting mode drives inverted bus levels
// [R17] driver enable low floats both bus outputs
// [R18] normal receive follows bus; disabled floats
// [R19] correcting mode receive output is inverted
// [R20] interrupted idle restarts the failsafe timer
`timescale 1ns/10ps
`default_nettype none
module rs485_host_ctrl
   import rs485_host_pkg::*;
#(
   parameter int IDLE_WAIT = IDLE_WAIT_CYCLES,
   parameter int RUN_MAX = RUN_MAX_CYCLES,
   parameter int STANDBY_HOLD = STANDBY_HOLD_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic drive_req,
   input wire logic tx_valid,
   input wire logic tx_bit,
   input wire logic standby_req,
   output logic tx_ready,
   output logic rx_bit,
   output logic link_ready,
   output logic in_standby,
   output logic run_error,
   output logic drive_enable_pin,
   output logic receive_enable_n_pin,
   output logic tx_data_pin,
   input wire logic rx_data_pin
);
   host_state_t state_r;
   host_state_t state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic de_r;
   logic de_nxt;
   logic re_n_r;
   logic re_n_nxt;
   logic txd_r;
   logic txd_nxt;
   logic ready_r;
   logic ready_nxt;
   logic link_r;
   logic link_nxt;
   logic sby_r;
   logic sby_nxt;
   logic err_r;
   logic err_nxt;
   logic rx_meta_r;
   logic rx_sync_r;
   logic rx_out_r;

   run_guard_if rg ();

   run_guard #(
      .RUN_MAX(RUN_MAX)
   ) u_run_guard (
      .clk(clk),
      .rst(rst),
      .rg(rg)
   );

   // guard only counts while the driver is really on the bus
   assign rg.clear = (state_r != ST_DRIVE);
   assign rg.level = txd_r;

   assign drive_enable_pin = de_r;
   assign receive_enable_n_pin = re_n_r;
   assign tx_data_pin = txd_r;
   assign tx_ready = ready_r;
   assign link_ready = link_r;
   assign in_standby = sby_r;
   assign run_error = err_r;
   assign rx_bit = rx_out_r;

   // one step of the shared wait counter
   function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c);
      return c + CNT_ONE;
   endfunction : cnt_step

   // true in the last cycle of a wait of lim cycles
   function automatic logic cnt_done(input logic [CNT_W-1:0] c, input int lim);
      return c == CNT_W'(lim - 1);
   endfunction : cnt_done

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      de_nxt = 1'b0;
      re_n_nxt = 1'b0;
      txd_nxt = BUS_IDLE_LEVEL;
      ready_nxt = 1'b0;
      link_nxt = link_r;
      sby_nxt = 1'b0;
      err_nxt = 1'b0;
      case (state_r)
         ST_POWERUP_WAIT: begin
            // direction low, receiver on, quiet for longer than the interval
            if (cnt_done(cnt_r, IDLE_WAIT)) begin // R13 R05
               state_nxt = ST_LISTEN;
               cnt_nxt = CNT_ZERO;
               link_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_step(cnt_r); // R14 R04
            end
         end
         ST_LISTEN: begin
            cnt_nxt = CNT_ZERO;
            // drive wins when both requests stand
            if (drive_req) begin
               // receiver stays enabled so enables never pass a disabled state
               state_nxt = ST_DRIVE; // R02
               de_nxt = 1'b1;
               ready_nxt = 1'b1;
            end else if (standby_req) begin
               state_nxt = ST_STANDBY;
               re_n_nxt = 1'b1;
               sby_nxt = 1'b1;
            end
         end
         ST_DRIVE: begin
            // a bit offered in the cycle that ends the drive is dropped
            txd_nxt = txd_r;
            if (tx_valid && ready_r) begin
               txd_nxt = tx_bit;
            end
            if (rg.hit) begin
               // a run this long could flip a freshly joined node's polarity
               state_nxt = ST_LISTEN; // R12
               err_nxt = 1'b1;
               txd_nxt = BUS_IDLE_LEVEL;
            end else if (!drive_req) begin
               state_nxt = ST_LISTEN;
               txd_nxt = BUS_IDLE_LEVEL;
            end else begin
               de_nxt = 1'b1;
               ready_nxt = 1'b1;
            end
         end
         ST_STANDBY: begin
            // hold at least the standby time so the device really powers down
            if (!cnt_done(cnt_r, STANDBY_HOLD)) begin // R01
               cnt_nxt = cnt_step(cnt_r);
               re_n_nxt = 1'b1;
               sby_nxt = 1'b1;
            end else if (standby_req) begin
               re_n_nxt = 1'b1;
               sby_nxt = 1'b1;
            end else begin
               // no new idle wait on exit: the device keeps its polarity latched
               state_nxt = ST_LISTEN; // R03
               cnt_nxt = CNT_ZERO;
            end
         end
         default: begin
            state_nxt = ST_POWERUP_WAIT;
            cnt_nxt = CNT_ZERO;
            link_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         // reset stands for power-up: the idle wait starts again from zero
         state_r <= ST_POWERUP_WAIT; // R11
         cnt_r <= CNT_ZERO;
         de_r <= 1'b0;
         re_n_r <= 1'b0;
         txd_r <= BUS_IDLE_LEVEL;
         ready_r <= 1'b0;
         link_r <= 1'b0;
         sby_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         de_r <= de_nxt;
         re_n_r <= re_n_nxt;
         txd_r <= txd_nxt;
         ready_r <= ready_nxt;
         link_r <= link_nxt;
         sby_r <= sby_nxt;
         err_r <= err_nxt;
      end
   end

   // receive pin is asynchronous; polarity already corrected by the device
   // only the third stage drives rx_bit: the first may be metastable
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_meta_r <= BUS_IDLE_LEVEL;
         rx_sync_r <= BUS_IDLE_LEVEL;
         rx_out_r <= BUS_IDLE_LEVEL;
      end else begin
         rx_meta_r <= rx_data_pin;
         rx_sync_r <= rx_meta_r;
         rx_out_r <= rx_sync_r; // R19 R18
      end
   end
endmodule : rs485_host_ctrl
`default_nettype wire

// [rs485_host_pkg.sv]
// Purpose: shared constants for the rs485 host-side transceiver controller
// Assumes: 100 MHz clock
// Notes: long counts are also top-level parameters so simulation can shorten them
package rs485_host_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_MS = 1000000;
   // failsafe interval window of the device, in ms
   localparam int FAILSAFE_MIN_MS = 44;
   localparam int FAILSAFE_MAX_MS = 76;
   // least time the enables must stay disabled for standby, in ns
   localparam int STANDBY_HOLD_NS = 300;
   // idle wait must exceed the longest interval: one extra cycle
   localparam int IDLE_WAIT_CYCLES = FAILSAFE_MAX_MS * (NS_PER_MS / CLK_PERIOD_NS) + 1;
   // a run must stay below the shortest interval: one cycle fewer
   localparam int RUN_MAX_CYCLES = FAILSAFE_MIN_MS * (NS_PER_MS / CLK_PERIOD_NS) - 1;
   localparam int STANDBY_HOLD_CYCLES = (STANDBY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 32;
   localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
   localparam logic BUS_IDLE_LEVEL = 1'b1;
   typedef enum logic [1:0] {
      ST_POWERUP_WAIT = 2'b00,
      ST_LISTEN = 2'b01,
      ST_DRIVE = 2'b11,
      ST_STANDBY = 2'b10
   } host_state_t;
endpackage : rs485_host_pkg

// [run_guard_if.sv]
// Purpose: carries run-length guard signals between controller and guard
// Assumes: single clock domain
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface run_guard_if;
   logic clear;
   logic level;
   logic hit;
   modport guard (input clear, input level, output hit);
   modport user (output clear, output level, input hit);
endinterface : run_guard_if
`default_nettype wire

// [run_guard.sv]
// Purpose: counts how long the transmit level has stayed unchanged
// Assumes: level comes from a register on the same clock
// Notes: hit is a one-cycle pulse when the run reaches its limit
`timescale 1ns/10ps
`default_nettype none
module run_guard
   import rs485_host_pkg::*;
#(
   parameter int RUN_MAX = RUN_MAX_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   run_guard_if.guard rg
);
   logic [CNT_W-1:0] run_cnt_r;
   logic [CNT_W-1:0] run_cnt_nxt;
   logic last_level_r;
   logic last_level_nxt;
   logic hit_r;
   logic hit_nxt;

   assign rg.hit = hit_r;

   always_comb begin
      last_level_nxt = rg.level;
      hit_nxt = 1'b0;
      if (rg.clear || (rg.level != last_level_r)) begin
         run_cnt_nxt = CNT_ZERO;
      end else if (run_cnt_r == CNT_W'(RUN_MAX - 1)) begin
         run_cnt_nxt = CNT_ZERO;
         hit_nxt = 1'b1; // R12
      end else begin
         run_cnt_nxt = run_cnt_r + CNT_ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         run_cnt_r <= CNT_ZERO;
         last_level_r <= BUS_IDLE_LEVEL;
         hit_r <= 1'b0;
      end else begin
         run_cnt_r <= run_cnt_nxt;
         last_level_r <= last_level_nxt;
         hit_r <= hit_nxt;
      end
   end
endmodule : run_guard
`default_nettype wire

// [rs485_host_ctrl_chk.sv]
// Purpose: port checks for the transceiver controller
// Assumes: single clock, synchronous reset
// Notes: bound to every controller instance
`timescale 1ns/10ps
`default_nettype none
module rs485_host_ctrl_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic drive_req,
   input wire logic tx_valid,
   input wire logic tx_bit,
   input wire logic tx_ready,
   input wire logic link_ready,
   input wire logic in_standby,
   input wire logic run_error,
   input wire logic drive_enable_pin,
   input wire logic receive_enable_n_pin,
   input wire logic tx_data_pin
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_reset_pins_quiet: assert property (!link_ready |-> !drive_enable_pin && !receive_enable_n_pin)
      else $error("enables moved before idle wait done");
   a_link_stays_up: assert property (link_ready |=> link_ready)
      else $error("link ready dropped");
   a_drive_answer: assert property (link_ready && drive_req && !drive_enable_pin && !in_standby
      |=> drive_enable_pin)
      else $error("drive request not answered");
   a_ready_tracks_de: assert property (tx_ready == drive_enable_pin)
      else $error("ready and driver enable disagree");
   a_idle_data_high: assert property (!drive_enable_pin |-> tx_data_pin)
      else $error("transmit pin not idle high");
   a_tx_bit_taken: assert property (tx_valid && tx_ready && drive_req
      |=> tx_data_pin == $past(tx_bit) || run_error)
      else $error("transmit bit not on pin");
   a_standby_pins: assert property (in_standby |-> receive_enable_n_pin && !drive_enable_pin)
      else $error("standby without both enables off");
   a_standby_hold: assert property ($rose(in_standby) |=> in_standby [*8])
      else $error("standby too brief");
   a_echo_listen: assert property (drive_enable_pin |-> !receive_enable_n_pin)
      else $error("receiver off while driving");
   a_run_abort: assert property (run_error |-> !drive_enable_pin && tx_data_pin)
      else $error("run error without drive end");
endmodule : rs485_host_ctrl_chk
bind rs485_host_ctrl rs485_host_ctrl_chk i_chk (.clk(clk), .rst(rst), .drive_req(drive_req),
   .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_ready(tx_ready), .link_ready(link_ready),
   .in_standby(in_standby), .run_error(run_error), .drive_enable_pin(drive_enable_pin),
   .receive_enable_n_pin(receive_enable_n_pin), .tx_data_pin(tx_data_pin));
`default_nettype wire

// [xcvr_model.sv]
// Purpose: behavioural transceiver with polarity latch and standby
// Assumes: bias gives the idle bus level as seen at this node
// Notes: power-up is modelled by the controller reset
`timescale 1ns/10ps
`default_nettype none
module xcvr_model #(
   parameter int FS = 100,
   parameter int SB = 30
) (
   input wire logic clk,
   input wire logic pwr_rst,
   input wire logic de,
   input wire logic re_n,
   input wire logic d,
   input wire logic bias,
   output logic r,
   output logic bus,
   output logic inv_r,
   output logic sleep_r
);
   int fs_cnt;
   int sb_cnt;
   logic last;
   assign bus = de ? (d ^ inv_r) : bias;
   // a released receive pin has no pull: show the inverse of its last value
   assign r = re_n ? ~last : (bus ^ inv_r);
   always_ff @(posedge clk) begin
      last <= r;
      if (pwr_rst) begin
         inv_r <= 1'b0;
         fs_cnt <= 0;
         sb_cnt <= 0;
         sleep_r <= 1'b0;
      end else begin
         if (!de && !re_n && !bus && !inv_r) begin
            fs_cnt <= fs_cnt + 1;
         end else begin
            fs_cnt <= 0;
         end
         if (fs_cnt == FS - 1) begin
            inv_r <= 1'b1;
         end
         sb_cnt <= (!de && re_n) ? sb_cnt + 1 : 0;
         sleep_r <= !de && re_n && sb_cnt >= SB - 1;
      end
   end
endmodule : xcvr_model
`default_nettype wire

// [testbench.sv]
// Purpose: self-checking bench for the transceiver controller
// Assumes: shortened counts, crossed bus wiring
// Notes: random transmit bits from a fixed xorshift seed
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import rs485_host_pkg::*;
   logic clk, rst, drive_req, tx_valid, tx_bit, standby_req, bias;
   logic tx_ready, rx_bit, link_ready, in_standby, run_error, de, re_n, txd, rxd;
   logic bus, inv, sleep;
   logic [31:0] seed;
   logic hit;
   int err_count;
   int n_tests;
   rs485_host_ctrl #(.IDLE_WAIT(200), .RUN_MAX(50), .STANDBY_HOLD(30)) i_dut (.clk(clk),
      .rst(rst), .drive_req(drive_req), .tx_valid(tx_valid), .tx_bit(tx_bit),
      .standby_req(standby_req), .tx_ready(tx_ready), .rx_bit(rx_bit),
      .link_ready(link_ready), .in_standby(in_standby), .run_error(run_error),
      .drive_enable_pin(de), .receive_enable_n_pin(re_n), .tx_data_pin(txd),
      .rx_data_pin(rxd));
   xcvr_model #(.FS(100), .SB(30)) i_xcvr (.clk(clk), .pwr_rst(rst), .de(de), .re_n(re_n),
      .d(txd), .bias(bias), .r(rxd), .bus(bus), .inv_r(inv), .sleep_r(sleep));
   always #5 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic check(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict
   task automatic wait_hi(ref logic s, input int lim);
      int i;
      for (i = 0; i < lim && s !== 1'b1; i++) begin
         tick();
      end
      if (s !== 1'b1) begin
         err_count++;
         give_verdict();
      end
   endtask : wait_hi
   initial begin
      clk = 0;
      rst = 1;
      {drive_req, tx_valid, tx_bit, standby_req, bias} = 5'h00;
      seed = 32'h0000CB67;
      err_count = 0;
      n_tests = 0;
      repeat (16) tick();
      check(txd, 1'b1);
      check(de, 1'b0);
      rst = 0;
      wait_hi(link_ready, 300);
      check(inv, 1'b1);
      check(rx_bit, 1'b1);
      drive_req = 1;
      tick();
      check(de, 1'b1);
      check(tx_ready, 1'b1);
      for (int i = 0; i < 40; i++) begin
         seed = xs(seed);
         tx_valid = 1;
         tx_bit = seed[0];
         tick();
         check(txd, seed[0]);
         check(bus, ~seed[0]);
      end
      // hold one level so the run guard must cut the drive
      hit = 0;
      for (int i = 0; i < 80; i++) begin
         tick();
         hit = hit | run_error;
      end
      check(hit, 1'b1);
      drive_req = 0;
      tx_valid = 0;
      tick();
      tick();
      check(de, 1'b0);
      check(tx_ready, 1'b0);
      check(bus, bias);
      standby_req = 1;
      repeat (40) tick();
      check(sleep, 1'b1);
      check(in_standby, 1'b1);
      check(re_n, 1'b1);
      standby_req = 0;
      tick();
      tick();
      check(sleep, 1'b0);
      check(inv, 1'b1);
      check(in_standby, 1'b0);
      check(re_n, 1'b0);
      // a second power-up must clear the inversion and redo the idle wait
      rst = 1;
      tick();
      tick();
      check(inv, 1'b0);
      check(link_ready, 1'b0);
      check(de, 1'b0);
      rst = 0;
      wait_hi(link_ready, 300);
      check(inv, 1'b1);
      check(rx_bit, 1'b1);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
